// File: nav_report_regs.vh
// Summary of operation
// [R1] a filter-control command with no data bytes is a query that returns the current settings and changes nothing.
// [R2] a filter-control set carries four bytes: position-velocity, static and altitude enables (0 off, 1 on) and a reserved byte.
// [R3] every filter-control command, query or set, is answered by a four-byte filter-control report laid out like the set.
// [R4] the static sub-filter engages only while enabled and while measured motion is very slow.
// [R5] the sentence configuration has subcode 0, an interval of 1 to 255 seconds and two reserved zero bytes.
// [R6] each sentence whose mask bit is set goes out once every interval; byte 4 bit 0 and byte 5 bits 0 to 5 are the mask.
// [R7] while fixes are produced the enabled sentences go out in the order ZDA, GGA, GLL, VTG, GSA, GSV, RMC.
// [R8] the settings report carries the interval and mask in the same layout as the configuration command.
// [R9] the one-byte differential mode report is sent on request and on each satellite selection in mode 2 or 3.
// [R10] in automatic mode the device moves between 2 and 3 by correction availability, and holds mode with no solution if no set qualifies.
// [R11] mode 0 solves without corrections always; mode 1 solves only with valid corrections.
// [R12] the differential mode report follows every position fix unless the mode is 0.
// [R13] the double ECEF position report goes out at each fix only when ECEF and double precision are both selected.
// [R14] the ECEF report holds X, Y, Z and clock bias as 8-byte doubles then fix time as a 4-byte single.
// [R15] the fix-time field is in GPS time or UTC as the timing option selects.
// [R16] the reserved fourth byte of a filter-control set is ignored and reported as a fixed value.
`ifndef NAV_REPORT_REGS_VH
`define NAV_REPORT_REGS_VH
`define CMD_FILTER 8'h70
`define CMD_NMEA_CFG 8'h7A
`define CMD_DIFF_REQ 8'h62
`define RPT_FILTER 8'h70
`define RPT_NMEA 8'h7B
`define RPT_DIFF 8'h82
`define RPT_ECEF 8'h83
`define FILTER_LEN 8'h04
`define NMEA_LEN 8'h06
`define ECEF_LEN 8'h24
`define FILTER_RSVD 8'h00
`define RST_FILTER 3'h7
`define RST_INTERVAL 8'h01
`define RST_MASK 7'h7F
`define RST_DIFF_MODE 2'h3
`define SEC_CYCLES 100000000
`define SENT_ZDA 3'h0
`define SENT_GGA 3'h1
`define SENT_GLL 3'h2
`define SENT_VTG 3'h3
`define SENT_GSA 3'h4
`define SENT_GSV 3'h5
`define SENT_RMC 3'h6
`endif

// File: sentence_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "nav_report_regs.vh"
// walks the enabled sentence list in fixed order, one per go
module sentence_sequencer (
	input wire sys_clk,
	input wire rst_b,
	// control
	input wire start,
	input wire [6:0] mask,
	input wire sent_ack,
	// output
	output reg sent_valid,
	output reg [2:0] sent_id
);
	reg [2:0] pos_reg;
	reg busy_reg;
	// mask bit index for each ordered slot: mask = {zda,gsa,gsv,vtg,gll,gga,rmc}
	function [2:0] slot_bit;
		input [2:0] slot;
		begin
			case (slot)
			3'h0: slot_bit = 3'h6;
			3'h1: slot_bit = 3'h1;
			3'h2: slot_bit = 3'h2;
			3'h3: slot_bit = 3'h3;
			3'h4: slot_bit = 3'h5;
			3'h5: slot_bit = 3'h4;
			default: slot_bit = 3'h0;
			endcase
		end
	endfunction
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pos_reg <= 3'h0;
			busy_reg <= 1'b0;
			sent_valid <= 1'b0;
			sent_id <= 3'h0;
		end else if (!busy_reg) begin
			sent_valid <= 1'b0;
			if (start) begin
				busy_reg <= 1'b1;
				pos_reg <= 3'h0;
			end
		end else if (sent_valid) begin
			if (sent_ack) begin
				sent_valid <= 1'b0;
				if (pos_reg == 3'h6)
					busy_reg <= 1'b0;
				pos_reg <= pos_reg + 3'h1;
			end
		end else if (pos_reg == 3'h7) begin
			busy_reg <= 1'b0;
		end else if (mask[slot_bit(pos_reg)]) begin
			sent_valid <= 1'b1; // [R7]
			sent_id <= pos_reg;
		end else begin
			if (pos_reg == 3'h6)
				busy_reg <= 1'b0;
			pos_reg <= pos_reg + 3'h1;
		end
	end
endmodule
`default_nettype wire

// File: nav_report_handler.v
`timescale 1ns/100ps
`default_nettype none
`include "nav_report_regs.vh"
module nav_report_handler #(
	parameter SEC_CYCLES = `SEC_CYCLES
) (
	input wire sys_clk,
	input wire rst_b,
	// command byte stream (packet framing done upstream)
	input wire cmd_valid,
	input wire cmd_first,
	input wire cmd_last,
	input wire [7:0] cmd_data,
	// report byte stream
	output reg rpt_valid,
	output reg rpt_first,
	output reg rpt_last,
	output reg [7:0] rpt_data,
	input wire rpt_ready,
	// navigation status (same clock domain)
	input wire fix_done,
	input wire sv_select,
	input wire slow_motion,
	input wire corr_avail,
	input wire constel_ok,
	input wire opt_ecef,
	input wire opt_double,
	input wire opt_utc,
	input wire [255:0] fix_words,
	input wire [31:0] time_gps,
	input wire [31:0] time_utc,
	// control inputs and outputs
	input wire [1:0] diff_mode_set,
	input wire diff_mode_load,
	output reg position_velocity_smoothing,
	output reg static_engaged,
	output reg alt_filter_en,
	output reg solve_en,
	output reg use_corr,
	output reg [1:0] diff_mode,
	output reg sent_valid,
	output reg [2:0] sent_id,
	input wire sent_ack
);
	// ----------------------------------------------------------------
	// command capture
	// ----------------------------------------------------------------
	reg [7:0] op_reg;
	reg [7:0] idx_reg;
	reg [7:0] b0_reg, b1_reg, b2_reg, b4_reg, b5_reg;
	reg static_en_reg;
	reg [7:0] interval_reg;
	reg [6:0] mask_reg;
	reg pend_filter, pend_nmea, pend_diff, pend_ecef;
	reg [2:0] kind_reg;
	reg [7:0] tx_idx;
	reg [7:0] tx_len;
	reg tx_busy;
	reg [287:0] snap_reg;
	reg [31:0] sec_cnt;
	reg [7:0] int_cnt;
	reg tick_reg;
	wire seq_valid;
	wire [2:0] seq_id;
	reg [2:0] kind_next;
	wire tx_start;
	wire cmd_end = cmd_valid & cmd_last;
	wire is_filter = cmd_first ? (cmd_data == `CMD_FILTER) :
		(op_reg == `CMD_FILTER);
	localparam K_FILTER = 3'h1;
	localparam K_NMEA = 3'h2;
	localparam K_DIFF = 3'h3;
	localparam K_ECEF = 3'h4;
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_reg <= 8'h00;
			idx_reg <= 8'h00;
			b0_reg <= 8'h00;
			b1_reg <= 8'h00;
			b2_reg <= 8'h00;
			b4_reg <= 8'h00;
			b5_reg <= 8'h00;
		end else if (cmd_valid) begin
			if (cmd_first) begin
				op_reg <= cmd_data;
				idx_reg <= 8'h00;
			end else begin
				idx_reg <= idx_reg + 8'h01;
				case (idx_reg)
				8'h00: b0_reg <= cmd_data;
				8'h01: b1_reg <= cmd_data;
				8'h02: b2_reg <= cmd_data;
				8'h04: b4_reg <= cmd_data;
				8'h05: b5_reg <= cmd_data;
				default: b4_reg <= b4_reg; // byte 3 ignored [R16]
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// settings, diff mode, pending reports
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			position_velocity_smoothing <= 1'b1;
			static_en_reg <= 1'b1;
			alt_filter_en <= 1'b1;
			interval_reg <= `RST_INTERVAL;
			mask_reg <= `RST_MASK;
			diff_mode <= `RST_DIFF_MODE;
			pend_filter <= 1'b0;
			pend_nmea <= 1'b0;
			pend_diff <= 1'b0;
			pend_ecef <= 1'b0;
			static_engaged <= 1'b0;
			solve_en <= 1'b0;
			use_corr <= 1'b0;
		end else begin
			static_engaged <= position_velocity_smoothing & static_en_reg &
				slow_motion; // [R4]
			// a filter command with four data bytes is a set; none is a query
			if (cmd_end && !cmd_first && is_filter && idx_reg == 8'h03) begin
				position_velocity_smoothing <= b0_reg[0]; // [R2]
				static_en_reg <= b1_reg[0];
				alt_filter_en <= b2_reg[0];
			end
			if (cmd_end && is_filter)
				pend_filter <= 1'b1; // [R1] [R3]
			else if (tx_start && kind_next == K_FILTER)
				pend_filter <= 1'b0;
			if (cmd_end && !cmd_first && op_reg == `CMD_NMEA_CFG &&
				idx_reg == 8'h05 && b0_reg == 8'h00 && b1_reg != 8'h00) begin
				interval_reg <= b1_reg; // [R5]
				mask_reg <= {cmd_data[5:0], b4_reg[0]}; // [R6]
				pend_nmea <= 1'b1; // [R8]
			end else if (tx_start && kind_next == K_NMEA)
				pend_nmea <= 1'b0;
			if (diff_mode_load)
				diff_mode <= diff_mode_set;
			else if (sv_select && diff_mode[1] && constel_ok)
				diff_mode <= corr_avail ? 2'h3 : 2'h2; // [R10]
			// set wins over the clear of a pending report
			if ((cmd_end && cmd_first && cmd_data == `CMD_DIFF_REQ) ||
				(sv_select && diff_mode[1]) ||
				(fix_done && diff_mode != 2'h0))
				pend_diff <= 1'b1; // [R9] [R12]
			else if (tx_start && kind_next == K_DIFF)
				pend_diff <= 1'b0;
			if (fix_done && opt_ecef && opt_double)
				pend_ecef <= 1'b1; // [R13]
			else if (tx_start && kind_next == K_ECEF)
				pend_ecef <= 1'b0;
			case (diff_mode)
			2'h0: begin
				solve_en <= 1'b1; // [R11]
				use_corr <= 1'b0;
			end
			2'h1: begin
				solve_en <= corr_avail; // [R11]
				use_corr <= 1'b1;
			end
			default: begin
				solve_en <= constel_ok; // [R10]
				use_corr <= diff_mode[0];
			end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// report transmitter
	// ----------------------------------------------------------------
	always @* begin
		if (pend_filter)
			kind_next = K_FILTER;
		else if (pend_nmea)
			kind_next = K_NMEA;
		else if (pend_diff)
			kind_next = K_DIFF;
		else if (pend_ecef)
			kind_next = K_ECEF;
		else
			kind_next = 3'h0;
	end
	assign tx_start = !tx_busy && kind_next != 3'h0;
	// payload byte, index 0 is the first data byte after the id
	function [7:0] pay_byte;
		input [2:0] k;
		input [7:0] i;
		input [287:0] s;
		begin
			case (k)
			K_FILTER: pay_byte = s[8*i +: 8];
			K_NMEA: pay_byte = s[8*i +: 8];
			K_DIFF: pay_byte = s[7:0];
			default: pay_byte = s[287 - 8*i -: 8]; // big-endian [R14]
			endcase
		end
	endfunction
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy <= 1'b0;
			kind_reg <= 3'h0;
			tx_idx <= 8'h00;
			tx_len <= 8'h00;
			snap_reg <= 288'h0;
			rpt_valid <= 1'b0;
			rpt_first <= 1'b0;
			rpt_last <= 1'b0;
			rpt_data <= 8'h00;
		end else if (tx_start) begin
			tx_busy <= 1'b1;
			kind_reg <= kind_next;
			tx_idx <= 8'h00;
			rpt_valid <= 1'b1;
			rpt_first <= 1'b1;
			rpt_last <= 1'b0;
			case (kind_next)
			K_FILTER: begin
				rpt_data <= `RPT_FILTER;
				tx_len <= `FILTER_LEN;
				snap_reg <= {256'h0, `FILTER_RSVD, 7'h00, alt_filter_en,
					7'h00, static_en_reg, 7'h00,
					position_velocity_smoothing}; // [R3] [R16]
			end
			K_NMEA: begin
				rpt_data <= `RPT_NMEA;
				tx_len <= `NMEA_LEN;
				snap_reg <= {240'h0, 2'h0, mask_reg[6:1], 7'h00, mask_reg[0],
					16'h0000, interval_reg, 8'h00}; // [R8]
			end
			K_DIFF: begin
				rpt_data <= `RPT_DIFF;
				tx_len <= 8'h01;
				snap_reg <= {280'h0, 6'h00, diff_mode}; // [R9]
			end
			default: begin
				rpt_data <= `RPT_ECEF;
				tx_len <= `ECEF_LEN;
				snap_reg <= {fix_words,
					opt_utc ? time_utc : time_gps}; // [R14] [R15]
			end
			endcase
		end else if (tx_busy && rpt_ready) begin
			rpt_first <= 1'b0;
			if (rpt_last) begin
				tx_busy <= 1'b0;
				rpt_valid <= 1'b0;
				rpt_last <= 1'b0;
			end else begin
				rpt_data <= pay_byte(kind_reg, tx_idx, snap_reg);
				tx_idx <= tx_idx + 8'h01;
				rpt_last <= (tx_idx + 8'h01 == tx_len);
			end
		end
	end
	// ----------------------------------------------------------------
	// sentence interval timer
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_cnt <= 32'h0;
			int_cnt <= 8'h00;
			tick_reg <= 1'b0;
			sent_valid <= 1'b0;
			sent_id <= 3'h0;
		end else begin
			tick_reg <= 1'b0;
			// the copy lags the sequencer a cycle, so drop it on ack
			sent_valid <= seq_valid & ~(sent_ack & sent_valid);
			sent_id <= seq_id;
			if (sec_cnt == SEC_CYCLES - 1) begin
				sec_cnt <= 32'h0;
				if (int_cnt + 8'h01 >= interval_reg) begin
					int_cnt <= 8'h00;
					tick_reg <= 1'b1; // [R6]
				end else
					int_cnt <= int_cnt + 8'h01;
			end else
				sec_cnt <= sec_cnt + 32'h1;
		end
	end
	sentence_sequencer seq (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.start(tick_reg),
		.mask(mask_reg),
		.sent_ack(sent_ack & sent_valid),
		.sent_valid(seq_valid),
		.sent_id(seq_id)
	);
endmodule
`default_nettype wire

// File: nav_report_handler_properties.sv
`timescale 1ns/100ps
`default_nettype none
module nav_report_handler_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// report stream
	input wire logic rpt_valid,
	input wire logic rpt_first,
	input wire logic rpt_last,
	input wire logic [7:0] rpt_data,
	input wire logic rpt_ready,
	// navigation status and control
	input wire logic slow_motion,
	input wire logic static_engaged,
	input wire logic corr_avail,
	input wire logic constel_ok,
	input wire logic diff_mode_load,
	input wire logic [1:0] diff_mode,
	input wire logic solve_en,
	input wire logic use_corr,
	// sentence requests
	input wire logic sent_valid,
	input wire logic [2:0] sent_id,
	input wire logic sent_ack
);
	// ----------------
	// properties
	// ----------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_held;
		rpt_valid && !rpt_ready;
	endsequence
	sequence s_done;
		rpt_valid && rpt_last && rpt_ready;
	endsequence
	property p_rpt_stands;
		s_held |=> rpt_valid && $stable(rpt_data);
	endproperty
	a_rpt_stands: assert property (p_rpt_stands)
		else $error("report byte changed while stalled");
	property p_rpt_id;
		rpt_valid && rpt_first |-> rpt_data inside {8'h70, 8'h7B, 8'h82, 8'h83};
	endproperty
	a_rpt_id: assert property (p_rpt_id)
		else $error("unknown report id");
	property p_rpt_end;
		s_done |=> !rpt_valid || rpt_first;
	endproperty
	a_rpt_end: assert property (p_rpt_end)
		else $error("report continued after its last byte");
	// one cycle of slack: the motion flag is sampled before use
	property p_static;
		(!slow_motion)[*2] |-> !static_engaged;
	endproperty
	a_static: assert property (p_static)
		else $error("static filter engaged while moving");
	property p_mode0;
		(diff_mode == 2'h0)[*2] |-> solve_en && !use_corr;
	endproperty
	a_mode0: assert property (p_mode0)
		else $error("mode 0 not solving plainly");
	property p_mode1;
		(diff_mode == 2'h1 && !corr_avail)[*2] |-> !solve_en;
	endproperty
	a_mode1: assert property (p_mode1)
		else $error("mode 1 solving without corrections");
	property p_hold;
		diff_mode[1] && !constel_ok && !$past(constel_ok) && !diff_mode_load
			&& !$past(diff_mode_load) |=> $stable(diff_mode);
	endproperty
	a_hold: assert property (p_hold)
		else $error("auto mode changed with no constellation");
	property p_sent_hold;
		sent_valid && !sent_ack |=> sent_valid && $stable(sent_id);
	endproperty
	a_sent_hold: assert property (p_sent_hold)
		else $error("sentence request dropped");
endmodule
bind nav_report_handler nav_report_handler_chk i_chk (.*);
`default_nettype wire

// File: host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock
	input wire logic sys_clk,
	// command stream
	output logic cmd_valid,
	output logic cmd_first,
	output logic cmd_last,
	output logic [7:0] cmd_data,
	// report stream
	input wire logic rpt_valid,
	input wire logic [7:0] rpt_data,
	output logic rpt_ready,
	// sentence requests
	input wire logic sent_valid,
	input wire logic [2:0] sent_id,
	output logic sent_ack
);
	// ----------------
	// host side
	// ----------------
	logic [7:0] rq[$];
	logic [2:0] sq[$];
	logic stall = 1'b0;
	logic seen = 1'b0;
	initial begin
		cmd_valid = 1'b0;
		cmd_first = 1'b0;
		cmd_last = 1'b0;
		cmd_data = 8'hA5;
		rpt_ready = 1'b1;
		sent_ack = 1'b0;
	end
	// opcode first, data bytes after; idle data is inverted, not held
	task automatic send(input logic [55:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			#1;
			cmd_valid = 1'b1;
			cmd_first = (i == 0);
			cmd_last = (i == n - 1);
			cmd_data = b[8*(n-1-i)+:8];
		end
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b0;
		cmd_data = ~cmd_data;
	endtask
	// slow mode takes a byte every other cycle
	always @(posedge sys_clk) begin
		if (rpt_valid && rpt_ready)
			rq.push_back(rpt_data);
		if (sent_valid && sent_ack)
			sq.push_back(sent_id);
		seen = sent_valid && !sent_ack;
		#1;
		rpt_ready = stall ? ~rpt_ready : 1'b1;
		// odd ids are taken a cycle late so a held request is exercised
		sent_ack = sent_valid && !sent_ack && (seen || !sent_id[0]);
	end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ----------------
	// signals
	// ----------------
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_valid, cmd_first, cmd_last, rpt_valid, rpt_first, rpt_last;
	logic rpt_ready, sent_valid, sent_ack, position_velocity_smoothing;
	logic alt_filter_en, solve_en, use_corr, static_engaged;
	logic [7:0] cmd_data, rpt_data;
	logic [2:0] sent_id;
	logic [1:0] diff_mode;
	logic [1:0] diff_mode_set = 2'h3;
	logic fix_done = 1'b0, sv_select = 1'b0, slow_motion = 1'b0;
	logic corr_avail = 1'b1, constel_ok = 1'b0, diff_mode_load = 1'b0;
	logic opt_ecef = 1'b0, opt_double = 1'b0, opt_utc = 1'b1;
	logic [255:0] fix_words = 256'h0;
	logic [31:0] time_gps = 32'h11223344, time_utc = 32'h55667788;
	int num_errors = 0, checked = 0;
	typedef struct {logic [55:0] c; int nc; logic [55:0] r; int nr;} row_t;
	row_t rows[5] = '{'{56'h70, 1, 56'h7001010100, 5},
		'{56'h70000100FF, 5, 56'h7000010000, 5},
		'{56'h70, 1, 56'h7000010000, 5},
		'{56'h7A00050000013F, 7, 56'h7B00050000013F, 7},
		'{56'h62, 1, 56'h8203, 2}};
	always #5 sys_clk = ~sys_clk;
	nav_report_handler #(.SEC_CYCLES(20)) i_nav_report_handler (.*);
	host_model i_host_model (.*);
	// ----------------
	// tasks
	// ----------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic take(input int n);
		for (int w = 0; w < 900 && i_host_model.rq.size() < n; w++)
			@(posedge sys_clk);
	endtask
	task automatic expect_rpt(input logic [55:0] v, input int n);
		take(n);
		for (int i = 0; i < n; i++)
			chk(i_host_model.rq[i], v[8*(n-1-i)+:8]);
		i_host_model.rq.delete();
	endtask
	task automatic pulse(ref logic s);
		@(posedge sys_clk);
		#1 s = 1'b1;
		@(posedge sys_clk);
		#1 s = 1'b0;
	endtask
	function automatic logic [7:0] ecef_exp(input int j);
		if (j < 3)
			return j == 0 ? 8'h82 : j == 1 ? 8'h03 : 8'h83;
		if (j < 35)
			return fix_words[279-8*j-:8];
		return time_utc[311-8*j-:8];
	endfunction
	// next slot of the fixed sentence order, wrapping after the last
	function automatic logic [7:0] nxt(input logic [2:0] s);
		return s == 3'h6 ? 8'h00 : {5'h00, s + 3'h1};
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------
	// tests
	// ----------------
	initial begin
		for (int i = 0; i < 32; i++)
			fix_words[255-8*i-:8] = i[7:0];
		repeat (3) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		foreach (rows[k]) begin
			i_host_model.stall = k[0];
			i_host_model.send(rows[k].c, rows[k].nc);
			expect_rpt(rows[k].r, rows[k].nr);
			$display("row %0d done", k);
		end
		chk({6'h00, position_velocity_smoothing, alt_filter_en}, 8'h00);
		#1 slow_motion = 1'b1;
		repeat (3) @(posedge sys_clk);
		chk({7'h00, static_engaged}, 8'h00);
		i_host_model.send(56'h7001010100, 5);
		expect_rpt(56'h7001010100, 5);
		repeat (2) @(posedge sys_clk);
		chk({7'h00, static_engaged}, 8'h01);
		#1 slow_motion = 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({7'h00, static_engaged}, 8'h00);
		$display("static filter done");
		i_host_model.send(56'h7A00000000013F, 7);
		repeat (50) @(posedge sys_clk);
		chk(8'(i_host_model.rq.size()), 8'h00);
		$display("refused config done");
		#1 opt_ecef = 1'b1;
		opt_double = 1'b1;
		pulse(fix_done);
		take(39);
		for (int j = 0; j < 39; j++)
			chk(i_host_model.rq[j], ecef_exp(j));
		i_host_model.rq.delete();
		pulse(sv_select);
		expect_rpt(56'h8203, 2);
		$display("fix reports done");
		#1 i_host_model.stall = 1'b0;
		diff_mode_set = 2'h0;
		opt_ecef = 1'b0;
		pulse(diff_mode_load);
		pulse(fix_done);
		repeat (50) @(posedge sys_clk);
		chk(8'(i_host_model.rq.size()), 8'h00);
		chk({6'h00, solve_en, use_corr}, 8'h02);
		i_host_model.sq.delete();
		for (int w = 0; w < 3000 && i_host_model.sq.size() < 8; w++)
			@(posedge sys_clk);
		chk(8'(i_host_model.sq.size() >= 8), 8'h01);
		for (int i = 0; i < 7; i++)
			chk(8'(i_host_model.sq[i+1]), nxt(i_host_model.sq[i]));
		$display("sentence order done");
		#1 diff_mode_set = 2'h1;
		corr_avail = 1'b0;
		pulse(diff_mode_load);
		repeat (4) @(posedge sys_clk);
		chk({7'h00, solve_en}, 8'h00);
		$display("mode checks done");
		#1 diff_mode_set = 2'h3;
		constel_ok = 1'b1;
		pulse(diff_mode_load);
		pulse(sv_select);
		expect_rpt(56'h8202, 2);
		chk({6'h00, diff_mode}, 8'h02);
		chk({6'h00, solve_en, use_corr}, 8'h02);
		#1 opt_utc = 1'b0;
		opt_ecef = 1'b1;
		pulse(fix_done);
		take(39);
		chk(i_host_model.rq[1], 8'h02);
		for (int j = 0; j < 4; j++)
			chk(i_host_model.rq[35+j], time_gps[31-8*j-:8]);
		i_host_model.rq.delete();
		$display("auto mode done");
		#1 rst_b = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		i_host_model.send(56'h70, 1);
		expect_rpt(56'h7001010100, 5);
		i_host_model.send(56'h62, 1);
		expect_rpt(56'h8203, 2);
		$display("mid-run reset done");
		close_out();
	end
	initial begin
		#400000;
		num_errors++;
		close_out();
	end
endmodule
`default_nettype wire
